// ---- rtl/zast_top.sv ----
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`include "zast_regs.svh"
module zast_top #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16,
  parameter int CW = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire zast_pkg::zast_word_t avs_writedata_i,
  output zast_pkg::zast_word_t avs_readdata_o,
  output logic avs_waitrequest_o,
  // External memory interface
  output logic [ADDR_W-1:0] external_address_bus_o,
  output logic [DATA_W-1:0] ext_data_o,
  output logic ext_data_oe_o,
  input wire logic [DATA_W-1:0] ext_data_i,
  output logic zone_select_n_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic read_not_write_o,
  input wire logic external_ready_i,
  output logic external_clock_output_o
);
  import zast_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  zast_tick_if tk ();
  zast_state_t state_r;
  zast_state_t st_nxt;
  logic [CW-1:0] seq_cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [16:0] timing_r;
  logic [1:0] clkcfg_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic [7:0] waits_r;
  logic done_r;
  logic go_r;
  logic dir_rd_r;
  logic acc_rd_r;
  logic waitreq_r;
  zast_word_t readdata_r;
  zast_word_t rd_mux;
  zast_word_t stat;
  logic [ADDR_W-1:0] ext_addr_r;
  logic [DATA_W-1:0] ext_data_r;
  logic ext_oe_r;
  logic zcs_n_r;
  logic rds_n_r;
  logic wrs_n_r;
  logic rnw_r;
  logic rdy_sync;
  logic rdy_async;
  logic rdy_ok;
  logic [DATA_W-1:0] data_s;
  logic bus_wr;
  logic bus_rd;
  logic busy;
  logic start;
  logic to_active;
  logic to_trail;
  logic finish;
  logic wait_tick;
  logic [2:0] lead_n;
  logic [2:0] act_n;
  logic [2:0] trl_n;
  logic [CW-1:0] lead_len;
  logic [CW-1:0] act_len;
  logic [CW-1:0] trl_len;
  logic [`ZAST_SYNC_STAGES-1:0] cap_r;

  ////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Phase length in ticks, doubled on request
  function automatic logic [CW-1:0] phase_len(input logic [2:0] n,
                                               input logic dbl);
    phase_len = dbl ? CW'({n, 1'b0}) : CW'(n);
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic zast_word_t be_merge(input zast_word_t old_w,
                                          input zast_word_t new_w,
                                          input logic [3:0] be);
    be_merge = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        be_merge[i*8 +: 8] = new_w[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Clock divider and synchronisers
  assign tk.tim_half = clkcfg_r[`ZAST_B_TIMHALF];
  assign tk.out_half = clkcfg_r[`ZAST_B_OUTHALF];

  zast_clkgen u_clkgen (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tk(tk.gen)
  );

  zast_sync #(.W(1), .STAGES(`ZAST_SYNC_STAGES)) u_rdy_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(external_ready_i),
    .q_o(rdy_sync)
  );

  // Deeper chain for asynchronous ready
  zast_sync #(.W(1), .STAGES(`ZAST_ASYNC_STAGES)) u_rdy_async (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(external_ready_i),
    .q_o(rdy_async)
  );

  zast_sync #(.W(DATA_W), .STAGES(`ZAST_SYNC_STAGES)) u_data_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(ext_data_i),
    .q_o(data_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Avalon handshake: one wait cycle, then answer
  assign bus_wr = avs_write_i & ~waitreq_r;
  assign bus_rd = avs_read_i & waitreq_r;
  assign busy = go_r | (state_r != ZAST_IDLE);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      waitreq_r <= 1'b1;
    else
      waitreq_r <= ~((avs_read_i | avs_write_i) & waitreq_r);
  end

  // Status word and read mux
  always_comb
  begin
    stat = 32'h0;
    stat[`ZAST_B_BUSY] = busy;
    stat[`ZAST_B_DONE] = done_r;
    stat[`ZAST_F_WAITS] = waits_r;
    case (avs_address_i)
      `ZAST_OFF_TIMING: rd_mux = 32'(timing_r);
      `ZAST_OFF_CLKCFG: rd_mux = 32'(clkcfg_r);
      `ZAST_OFF_ADDR: rd_mux = 32'(addr_r);
      `ZAST_OFF_DATA: rd_mux = 32'(rdata_r);
      `ZAST_OFF_CMD: rd_mux = stat;
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data stands while waitrequest is low
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      readdata_r <= 32'h0;
    else if (bus_rd)
      readdata_r <= rd_mux;
  end

  // Configuration registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      timing_r <= `ZAST_TIMING_RST;
      clkcfg_r <= `ZAST_CLKCFG_RST;
      addr_r <= '0;
      wdata_r <= '0;
    end
    else if (bus_wr)
    begin
      case (avs_address_i)
        `ZAST_OFF_TIMING: timing_r <= 17'(be_merge(32'(timing_r),
                                 avs_writedata_i, avs_byteenable_i));
        `ZAST_OFF_CLKCFG: clkcfg_r <= 2'(be_merge(32'(clkcfg_r),
                                 avs_writedata_i, avs_byteenable_i));
        `ZAST_OFF_ADDR: addr_r <= ADDR_W'(be_merge(32'(addr_r),
                                 avs_writedata_i, avs_byteenable_i));
        `ZAST_OFF_DATA: wdata_r <= DATA_W'(be_merge(32'(wdata_r),
                                 avs_writedata_i, avs_byteenable_i));
        default: ;
      endcase
    end
  end

  // Command: start request latched, ignored while busy
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      go_r <= 1'b0;
      dir_rd_r <= 1'b0;
    end
    else if (start)
      go_r <= 1'b0;
    else if (bus_wr && avs_address_i == `ZAST_OFF_CMD && !busy &&
             avs_byteenable_i[0] && avs_writedata_i[`ZAST_B_START])
    begin
      go_r <= 1'b1;
      dir_rd_r <= avs_writedata_i[`ZAST_B_DIRRD];
    end
  end

  // Done flag: set by access end, wins over clear
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      done_r <= 1'b0;
    else if (finish)
      done_r <= 1'b1;
    else if (bus_wr && avs_address_i == `ZAST_OFF_CMD &&
             avs_byteenable_i[0] && avs_writedata_i[`ZAST_B_CLRDONE])
      done_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase lengths for the access direction
  always_comb
  begin
    if (start ? dir_rd_r : acc_rd_r)
    begin
      lead_n = {1'b0, timing_r[`ZAST_F_RDLEAD]};
      act_n = timing_r[`ZAST_F_RDACT];
      trl_n = {1'b0, timing_r[`ZAST_F_RDTRL]};
    end
    else
    begin
      lead_n = {1'b0, timing_r[`ZAST_F_WRLEAD]};
      act_n = timing_r[`ZAST_F_WRACT];
      trl_n = {1'b0, timing_r[`ZAST_F_WRTRL]};
    end
    lead_len = phase_len(lead_n, timing_r[`ZAST_B_DBL]);
    act_len = phase_len(act_n, timing_r[`ZAST_B_DBL]);
    trl_len = phase_len(trl_n, timing_r[`ZAST_B_DBL]);
  end

  // Ready gate: ignored, synchronous or asynchronous sampling
  always_comb
  begin
    if (!timing_r[`ZAST_B_RUSE])
      rdy_ok = 1'b1;
    else if (timing_r[`ZAST_B_RASYNC])
      rdy_ok = rdy_async;
    else
      rdy_ok = rdy_sync;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state, advancing only on timing ticks
  always_comb
  begin
    st_nxt = state_r;
    cnt_nxt = seq_cnt_r;
    start = 1'b0;
    to_active = 1'b0;
    to_trail = 1'b0;
    finish = 1'b0;
    wait_tick = 1'b0;
    if (tk.tick)
    begin
      case (state_r)
        ZAST_IDLE:
        begin
          if (go_r && tk.out_rise)
            start = 1'b1;
          else if (go_r)
            st_nxt = ZAST_ALIGN;
        end
        ZAST_ALIGN:
        begin
          if (tk.out_rise)
            start = 1'b1;
        end
        ZAST_LEAD:
        begin
          if (seq_cnt_r == '0)
            to_active = 1'b1;
          else
            cnt_nxt = CW'(seq_cnt_r - 1'b1);
        end
        ZAST_ACTIVE:
        begin
          if (seq_cnt_r != '0)
            cnt_nxt = CW'(seq_cnt_r - 1'b1);
          else if (rdy_ok)
            to_trail = 1'b1;
          else
            wait_tick = 1'b1;
        end
        ZAST_TRAIL:
        begin
          if (seq_cnt_r == '0)
            finish = 1'b1;
          else
            cnt_nxt = CW'(seq_cnt_r - 1'b1);
        end
        default: st_nxt = ZAST_IDLE;
      endcase
    end
    // Zero-length lead and trail phases fall straight through; no legality
    if (start && lead_len != '0)
    begin
      st_nxt = ZAST_LEAD;
      cnt_nxt = CW'(lead_len - 1'b1);
    end
    else if (start)
      to_active = 1'b1;
    if (to_active)
    begin
      st_nxt = ZAST_ACTIVE;
      cnt_nxt = act_len;
    end
    if (to_trail && trl_len != '0)
    begin
      st_nxt = ZAST_TRAIL;
      cnt_nxt = CW'(trl_len - 1'b1);
    end
    else if (to_trail)
      finish = 1'b1;
    if (finish)
      st_nxt = ZAST_IDLE;
  end

  // Sequencer state and phase counter
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ZAST_IDLE;
      seq_cnt_r <= '0;
    end
    else
    begin
      state_r <= st_nxt;
      seq_cnt_r <= cnt_nxt;
    end
  end

  // Access direction latched at start
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      acc_rd_r <= 1'b0;
    else if (start)
      acc_rd_r <= dir_rd_r;
  end

  // Ready wait-state counter
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      waits_r <= 8'h00;
    else if (start)
      waits_r <= 8'h00;
    else if (wait_tick && waits_r != 8'hFF)
      waits_r <= 8'(waits_r + 8'h01);
  end

  ////////////////////////////////////////////////////////////////////////
  // Zone select and read/write line
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      zcs_n_r <= 1'b1;
      rnw_r <= 1'b1;
    end
    else if (start)
    begin
      zcs_n_r <= 1'b0;
      rnw_r <= dir_rd_r;
    end
    else if (finish)
    begin
      zcs_n_r <= 1'b1;
      rnw_r <= 1'b1;
    end
  end

  // Read and write strobes over the active phase
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rds_n_r <= 1'b1;
      wrs_n_r <= 1'b1;
    end
    else if (to_active)
    begin
      rds_n_r <= ~(start ? dir_rd_r : acc_rd_r);
      wrs_n_r <= (start ? dir_rd_r : acc_rd_r);
    end
    else if (to_trail)
    begin
      rds_n_r <= 1'b1;
      wrs_n_r <= 1'b1;
    end
  end

  // Address held between accesses and in alignment
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      ext_addr_r <= '0;
    else if (start)
      ext_addr_r <= addr_r;
  end

  // Write data drive for the whole write access
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_data_r <= '0;
      ext_oe_r <= 1'b0;
    end
    else if (start)
    begin
      ext_data_r <= wdata_r;
      ext_oe_r <= ~dir_rd_r;
    end
    else if (finish)
      ext_oe_r <= 1'b0;
  end

  // Capture delay matching the data synchroniser depth
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cap_r <= '0;
    else
      cap_r <= {cap_r[`ZAST_SYNC_STAGES-2:0], to_trail & acc_rd_r};
  end

  // Read data as the bus stood at read strobe release
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_r <= '0;
    else if (cap_r[`ZAST_SYNC_STAGES-1])
      rdata_r <= data_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata_o = readdata_r;
  assign avs_waitrequest_o = waitreq_r;
  assign external_address_bus_o = ext_addr_r;
  assign ext_data_o = ext_data_r;
  assign ext_data_oe_o = ext_oe_r;
  assign zone_select_n_o = zcs_n_r;
  assign read_strobe_n_o = rds_n_r;
  assign write_strobe_n_o = wrs_n_r;
  assign read_not_write_o = rnw_r;
  assign external_clock_output_o = tk.clk_lvl;
endmodule // zast_top

// ---- rtl/zast_regs.svh ----
`ifndef ZAST_REGS_SVH
`define ZAST_REGS_SVH

// Register byte offsets
`define ZAST_OFF_TIMING 5'h00
`define ZAST_OFF_CLKCFG 5'h04
`define ZAST_OFF_ADDR 5'h08
`define ZAST_OFF_DATA 5'h0C
`define ZAST_OFF_CMD 5'h10

// Zone timing register fields
`define ZAST_F_RDLEAD 1:0
`define ZAST_F_RDACT 4:2
`define ZAST_F_RDTRL 6:5
`define ZAST_F_WRLEAD 8:7
`define ZAST_F_WRACT 11:9
`define ZAST_F_WRTRL 13:12
`define ZAST_B_DBL 14
`define ZAST_B_RUSE 15
`define ZAST_B_RASYNC 16
`define ZAST_TIMING_RST 17'h07FFF

// Clock configuration fields
`define ZAST_B_TIMHALF 0
`define ZAST_B_OUTHALF 1
`define ZAST_CLKCFG_RST 2'h3

// Command (write) and status (read) fields
`define ZAST_B_START 0
`define ZAST_B_DIRRD 1
`define ZAST_B_CLRDONE 2
`define ZAST_B_BUSY 0
`define ZAST_B_DONE 1
`define ZAST_F_WAITS 15:8

// Divider periods minus one, in clk cycles
`define ZAST_TIM_M1_FULL 3'h1
`define ZAST_TIM_M1_HALF 3'h3
`define ZAST_PER_M1_MAX 3'h7

// Synchroniser depths
`define ZAST_SYNC_STAGES 2
`define ZAST_ASYNC_STAGES 3
`endif

// ---- rtl/zast_pkg.sv ----
package zast_pkg;
  typedef logic [31:0] zast_word_t;
  typedef enum logic [4:0] {
    ZAST_IDLE = 5'h01,
    ZAST_ALIGN = 5'h02,
    ZAST_LEAD = 5'h04,
    ZAST_ACTIVE = 5'h08,
    ZAST_TRAIL = 5'h10
  } zast_state_t;
endpackage

// ---- rtl/zast_tick_if.sv ----
interface zast_tick_if;
  logic tim_half;
  logic out_half;
  logic tick;
  logic out_rise;
  logic clk_lvl;
  modport gen (input tim_half, input out_half,
               output tick, output out_rise, output clk_lvl);
  modport use_side (output tim_half, output out_half,
                    input tick, input out_rise, input clk_lvl);
endinterface

// ---- rtl/zast_clkgen.sv ----
`include "zast_regs.svh"
module zast_clkgen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Tick carrier
  zast_tick_if.gen tk
);
  import zast_pkg::*;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] tim_m1;
  logic [2:0] per_m1;
  logic clk_lvl_r;

  ////////////////////////////////////////////////////////////////////////
  // Period selection: timing tick every other clk, every fourth with tim_half
  always_comb
  begin
    tim_m1 = tk.tim_half ? `ZAST_TIM_M1_HALF : `ZAST_TIM_M1_FULL;
    per_m1 = tk.out_half ? 3'((tim_m1 << 1) | 3'h1) : tim_m1;
    cnt_nxt = (cnt_r >= per_m1) ? 3'h0 : 3'(cnt_r + 3'h1);
  end

  // Phase counter over one output clock period
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cnt_r <= 3'h0;
    else
      cnt_r <= cnt_nxt;
  end

  // Output clock high in first half, lagging to match output flops
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      clk_lvl_r <= 1'b0;
    else
      clk_lvl_r <= (cnt_r <= (per_m1 >> 1));
  end

  // Timing tick and output rising tick
  assign tk.tick = ((cnt_r & tim_m1) == 3'h0);
  assign tk.out_rise = (cnt_r == 3'h0);
  assign tk.clk_lvl = clk_lvl_r;
endmodule // zast_clkgen

// ---- rtl/zast_sync.sv ----
module zast_sync #(
  parameter int W = 1,
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] st_r [STAGES];

  // First stage, read only by the second
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      st_r[0] <= '0;
    else
      st_r[0] <= d_i;
  end

  // Further stages
  for (genvar i = 1; i < STAGES; i++)
  begin : g_stage
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        st_r[i] <= '0;
      else
        st_r[i] <= st_r[i-1];
    end
  end

  assign q_o = st_r[STAGES-1];
endmodule // zast_sync

// ---- sim/zast_chk.sv ----
module zast_chk #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus handshake
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // Memory pins
  input wire logic [ADDR_W-1:0] external_address_bus_o,
  input wire logic [DATA_W-1:0] ext_data_o,
  input wire logic ext_data_oe_o,
  input wire logic zone_select_n_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic read_not_write_o,
  input wire logic external_clock_output_o
);
  logic req, wt, cs, rd, we, rnw, ck;
  // Short names for the watched pins
  assign req = avs_read_i | avs_write_i;
  assign wt = avs_waitrequest_o;
  assign cs = zone_select_n_o;
  assign rd = read_strobe_n_o;
  assign we = write_strobe_n_o;
  assign rnw = read_not_write_o;
  assign ck = external_clock_output_o;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  // Bus answers after one wait cycle, then idles high
  property p_ack; req && wt |=> !wt; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_rel; !wt |=> wt; endproperty
  a_rel: assert property (p_rel) else $error("wait low too long");
  // Address moves only when an access starts
  property p_addr; $changed(external_address_bus_o) |-> $fell(cs); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  // Access start on output clock rising
  property p_start; $fell(cs) |-> $rose(ck); endproperty
  a_start: assert property (p_start) else $error("start off rising");
  property p_rnw; $fell(rnw) |-> $fell(cs); endproperty
  a_rnw: assert property (p_rnw) else $error("direction low early");
  // Strobe edges land on an output clock edge
  property p_edge; $changed(rd) || $changed(we) |-> $changed(ck); endproperty
  a_edge: assert property (p_edge) else $error("strobe off edge");
  property p_end; $rose(cs) |-> $changed(ck) && rnw; endproperty
  a_end: assert property (p_end) else $error("bad access end");
  // Controls stay inactive outside an access
  property p_idle; cs |-> rd && we && rnw && !ext_data_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("control active");
  property p_wr; !we |-> !cs && !rnw && rd; endproperty
  a_wr: assert property (p_wr) else $error("write strobe alone");
  property p_rd; !rd |-> !cs && rnw; endproperty
  a_rd: assert property (p_rd) else $error("read strobe alone");
  property p_oe; ext_data_oe_o == (!cs && !rnw); endproperty
  a_oe: assert property (p_oe) else $error("data enable wrong");
  property p_wdat; !we && !$past(we) |-> $stable(ext_data_o); endproperty
  a_wdat: assert property (p_wdat) else $error("write data moved");
  // Main traffic seen
  c_wr: cover property ($fell(we));
  c_rd: cover property ($fell(rd));
  c_ack: cover property (!wt && avs_read_i);
endmodule // zast_chk

// ---- sim/zast_mem.sv ----
module zast_mem (
  // Clock
  input wire logic clk_i,
  // Memory pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic we_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic [7:0] slow_i,
  output logic [15:0] data_o,
  output logic ready_o
);
  logic [15:0] mem [16];
  logic [15:0] last_r = 16'h0000;
  logic [7:0] cnt_r = 8'h00;
  logic we_q = 1'b1;
  logic tgl_r = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // Write lands as strobe releases; count cycles of selection
  always @(posedge clk_i)
  begin
    we_q <= we_n_i;
    tgl_r <= ~tgl_r;
    if (!we_q && we_n_i)
      mem[addr_i[3:0]] <= data_i;
    if (!cs_n_i && !rd_n_i)
      last_r <= data_o;
    cnt_r <= cs_n_i ? 8'h00 : cnt_r + 8'h01;
  end
  // Data only while read strobe low, otherwise the inverse
  assign data_o = (!cs_n_i && !rd_n_i) ? mem[addr_i[3:0]] : ~last_r;
  // Ready after slow_i cycles; toggles when not selected
  assign ready_o = cs_n_i ? tgl_r : (cnt_r >= slow_i);
endmodule // zast_mem

// ---- sim/test_zone_access_strobe_timing.sv ----
module test_zone_access_strobe_timing;
  timeunit 1ns;
  timeprecision 1ns;
  import zast_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  zast_word_t avs_writedata_i = 32'h00000000;
  zast_word_t avs_readdata_o, rdq;
  logic avs_waitrequest_o, oe, cs, rd, we, rnw, rdy, ck, st, cs_q, st_q, ck_q;
  logic [18:0] xa;
  logic [15:0] xd_o, xd_i;
  logic [7:0] slow = 8'h00;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0, t1, t2, t3, tr, per;
  zast_top i_zast_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(4'hF), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .external_address_bus_o(xa), .ext_data_o(xd_o), .ext_data_oe_o(oe),
    .ext_data_i(xd_i), .zone_select_n_o(cs), .read_strobe_n_o(rd),
    .write_strobe_n_o(we), .read_not_write_o(rnw),
    .external_ready_i(rdy), .external_clock_output_o(ck)
  );
  zast_mem i_zast_mem (
    .clk_i(clk_i), .cs_n_i(cs), .rd_n_i(rd), .we_n_i(we), .addr_i(xa),
    .data_i(xd_o), .slow_i(slow), .data_o(xd_i), .ready_o(rdy)
  );
  ////////////////////////////////////////////////////////////////////////
  // Clock
  always #50 clk_i = ~clk_i;
  // Cycle stamps of select, strobe and output clock edges
  assign st = rd & we;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    cs_q <= cs;
    st_q <= st;
    ck_q <= ck;
    if (cs_q && !cs)
      t0 <= cyc;
    if (st_q && !st)
      t1 <= cyc;
    if (!st_q && st)
      t2 <= cyc;
    if (!cs_q && cs)
      t3 <= cyc;
    if (!ck_q && ck)
    begin
      per <= cyc - tr;
      tr <= cyc;
    end
  end
  // Verdict and exit
  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task timeout();
    n_errors++;
    $display("ERROR wait expected done seen timeout");
    end_of_test();
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // One bus cycle; read data lands in rdq
  task bus(input logic w, input logic [4:0] a, input zast_word_t d);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 40);
    rdq = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0)
      timeout();
  endtask
  // One external access; f is {async, use ready, doubling}
  task acc(input logic r, input logic [2:0] l, a, t, f, input logic [1:0] c,
           input logic [7:0] s, input logic [18:0] ad, input logic [15:0] dt);
    int m, p, w, n;
    m = f[0] ? 2 : 1;
    p = c[0] ? 4 : 2;
    slow <= s;
    bus(1'b1, 5'h00, {15'h0000, f, t[1:0], a, l[1:0], t[1:0], a, l[1:0]});
    bus(1'b1, 5'h04, {30'h00000000, c});
    bus(1'b1, 5'h08, {13'h0000, ad});
    bus(1'b1, 5'h0C, {16'h0000, dt});
    bus(1'b1, 5'h10, {29'h00000000, 1'b1, r, 1'b1});
    n = 0;
    do
    begin
      bus(1'b0, 5'h10, 32'h00000000);
      n++;
    end
    while (rdq[1] !== 1'b1 && n < 100);
    if (rdq[1] !== 1'b1)
      timeout();
    w = rdq[15:8];
    if (!f[1])
      chk("waits", 0, w);
    else if (s != 0)
      chk("waited", 1, w != 0);
    chk("lead", l * m * p, t1 - t0);
    chk("active", (a * m + 1 + w) * p, t2 - t1);
    chk("trail", t * m * p, t3 - t2);
    chk("addr", ad, xa);
    if (r)
    begin
      bus(1'b0, 5'h0C, 32'h00000000);
      chk("rdata", dt, rdq[15:0]);
    end
    else
      chk("mem", dt, i_zast_mem.mem[ad[3:0]]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Register reset values and an unmapped place
  task t_regs();
    bus(1'b0, 5'h00, 32'h00000000);
    chk("timing", 32'h00007FFF, rdq);
    bus(1'b0, 5'h04, 32'h00000000);
    chk("clkcfg", 32'h00000003, rdq);
    bus(1'b0, 5'h10, 32'h00000000);
    chk("status", 32'h00000000, rdq);
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    bus(1'b0, 5'h14, 32'h00000000);
    chk("unmapped", 32'h00000000, rdq);
    $display("t_regs done");
  endtask
  // Output clock period for all four clock settings
  task t_clk();
    int e [4];
    e = '{2, 4, 4, 8};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 5'h04, i);
      repeat (20) @(posedge clk_i);
      chk("period", e[i], per);
    end
    $display("t_clk done");
  endtask
  // Plain write, doubled read back
  task t_walk();
    acc(1'b0, 1, 0, 0, 3'b000, 2'h0, 8'h00, 19'h00005, 16'hA5C3);
    acc(1'b1, 2, 1, 1, 3'b001, 2'h1, 8'h00, 19'h00005, 16'hA5C3);
    $display("t_walk done");
  endtask
  // Half rate output clock with odd and even counts
  task t_half();
    acc(1'b0, 1, 1, 1, 3'b000, 2'h3, 8'h00, 19'h7FFF3, 16'h3C5A);
    acc(1'b1, 1, 2, 0, 3'b000, 2'h2, 8'h00, 19'h7FFF3, 16'h3C5A);
    $display("t_half done");
  endtask
  // Slow ready in both modes, then ready ignored
  task t_ready();
    acc(1'b0, 1, 1, 0, 3'b010, 2'h2, 8'h28, 19'h00009, 16'h0FF0);
    acc(1'b1, 1, 2, 0, 3'b110, 2'h0, 8'h28, 19'h00009, 16'h0FF0);
    acc(1'b0, 1, 0, 0, 3'b100, 2'h0, 8'h28, 19'h0000A, 16'hC3A5);
    acc(1'b1, 1, 0, 0, 3'b000, 2'h0, 8'h00, 19'h0000A, 16'hC3A5);
    $display("t_ready done");
  endtask
  // Illegal counts still run; doubled one-one read
  task t_illegal();
    acc(1'b0, 0, 0, 0, 3'b110, 2'h0, 8'h00, 19'h0000C, 16'h1234);
    acc(1'b1, 1, 1, 0, 3'b111, 2'h1, 8'h00, 19'h0000C, 16'h1234);
    $display("t_illegal done");
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_clk();
    t_walk();
    t_half();
    t_ready();
    t_illegal();
    end_of_test();
  end
endmodule // test_zone_access_strobe_timing
bind zast_top zast_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_zast_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .external_address_bus_o(external_address_bus_o), .ext_data_o(ext_data_o),
  .ext_data_oe_o(ext_data_oe_o), .zone_select_n_o(zone_select_n_o),
  .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
  .read_not_write_o(read_not_write_o),
  .external_clock_output_o(external_clock_output_o)
);
